// ---- atrb_fuse_rom.sv ----
// Fuse storage model: small read-only word store with registered read data.
// Assumes fuse contents are presented on a flat input bus from the fuse macro.
`timescale 1ns/1ps
`default_nettype none
module atrb_fuse_rom
#(
    parameter int WORDS = 8,
    parameter int WIDTH = 16
)
(
    // Clock
    input wire logic clk,
    input wire logic clkEn,
    // Fuse array
    input wire logic [WORDS*WIDTH-1:0] fuseBits,
    // Read port
    input wire logic [$clog2(WORDS)-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData
);
    // Elaboration check on the store shape
    generate
        if (WORDS < 2 || WIDTH < 1 || (1 << $clog2(WORDS)) != WORDS)
        begin : gShapeCheck
            $error("fuse store needs a power of two words, at least two");
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (clkEn)
        begin
            rdData <= fuseBits[rdAddr*WIDTH +: WIDTH];
        end
    end
endmodule : atrb_fuse_rom
`default_nettype wire

// ---- atrb_pkg.sv ----
// Package for the trim register bank: offsets, field layout, reset values, states.
// Assumes an APB slave with 32-bit data and byte addressing.
package atrb_pkg;
    // Printed offsets are register indices; byte address is four times the index
    localparam logic [11:0] IDX_CORE0_GAIN = 12'h0360;
    localparam logic [11:0] IDX_CORE1_GAIN = 12'h0361;
    localparam logic [11:0] IDX_CORE2A_GAIN = 12'h0362;
    localparam logic [11:0] IDX_CORE2B_GAIN = 12'h0363;
    localparam logic [11:0] IDX_CORE3C_GAIN = 12'h0364;
    localparam logic [11:0] IDX_CORE3D_GAIN = 12'h0365;
    localparam logic [11:0] IDX_CORE4_GAIN = 12'h0366;
    localparam logic [11:0] IDX_CORE5_OFFSET = 12'h033E;
    localparam int ADDR_W = 14;
    localparam int NUM_GAIN = 7;
    localparam int GAIN_W = 5;
    localparam int GAIN_REG_W = 8;
    localparam int OFFSET_W = 12;
    localparam int OFFSET_REG_W = 16;
    localparam logic [GAIN_REG_W-1:0] GAIN_RESET = 8'h00;
    localparam logic [OFFSET_REG_W-1:0] OFFSET_RESET = 16'h0000;
    localparam int FUSE_WORDS = 8;
    localparam int FUSE_IDX_OFFSET = 7;
    localparam logic [2:0] FUSE_LAST = 3'h7;
    typedef enum logic [1:0] {LD_IDLE, LD_ADDR, LD_WAIT, LD_DONE} atrb_load_t;
endpackage : atrb_pkg

// ---- atrb_trim_bank.sv ----
// Calibration trim register bank: seven fine gain trims and one core 5 offset trim.
// Assumes an APB master on clk and fuse contents that are stable after reset.
// Contract
// - Core 0 gain trim at 0x360, value bits 4:0, bits 7:5 reserved.
// - Core 1 gain trim at 0x361 holds a 5-bit fine gain value.
// - Trim at 0x362 drives core 2 only while sampling first pair.
// - Trim at 0x363 drives core 2 only while sampling second pair.
// - Trim at 0x364 drives core 3 only while sampling third pair.
// - Trim at 0x365 drives core 3 only while sampling fourth pair.
// - Core 4 gain trim at 0x366, bits 4:0, reset value zero.
// - Core 5 offset trim is 12 bits at 11:0, bits 15:12 reserved.
// - Gain trim defaults are loaded from fuse storage after reset.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module atrb_trim_bank
    import atrb_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic clkEn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Fuse storage
    input wire logic [FUSE_WORDS*OFFSET_REG_W-1:0] fuseBits,
    // Input pair selection, asynchronous pins
    input wire logic core2SecondPairSel,
    input wire logic core3FourthPairSel,
    // Trims applied to converter cores
    output logic [GAIN_W-1:0] core0Gain,
    output logic [GAIN_W-1:0] core1Gain,
    output logic [GAIN_W-1:0] core2Gain,
    output logic [GAIN_W-1:0] core3Gain,
    output logic [GAIN_W-1:0] core4Gain,
    output logic [OFFSET_W-1:0] core5Offset,
    output logic fuseLoadDone
);
    // Register decode, index of the gain trim or NUM_GAIN for offset
    function automatic logic [3:0] decodeIdx(input logic [ADDR_W-1:0] addr);
        logic [11:0] idx;
        idx = addr[ADDR_W-1:2];
        case (idx)
            IDX_CORE0_GAIN: decodeIdx = 4'h0;
            IDX_CORE1_GAIN: decodeIdx = 4'h1;
            IDX_CORE2A_GAIN: decodeIdx = 4'h2;
            IDX_CORE2B_GAIN: decodeIdx = 4'h3;
            IDX_CORE3C_GAIN: decodeIdx = 4'h4;
            IDX_CORE3D_GAIN: decodeIdx = 4'h5;
            IDX_CORE4_GAIN: decodeIdx = 4'h6;
            IDX_CORE5_OFFSET: decodeIdx = 4'h7;
            default: decodeIdx = 4'hF;
        endcase
    endfunction : decodeIdx

    // Trim in use for a core with two input pairs
    function automatic logic [GAIN_W-1:0] pickTrim(
        input logic useSecond,
        input logic [GAIN_REG_W-1:0] firstTrim,
        input logic [GAIN_REG_W-1:0] secondTrim
    );
        pickTrim = useSecond ? secondTrim[GAIN_W-1:0] : firstTrim[GAIN_W-1:0];
    endfunction : pickTrim

    logic [GAIN_REG_W-1:0] gain_reg [NUM_GAIN];
    logic [OFFSET_REG_W-1:0] offset_reg;
    logic [3:0] accIdx;
    logic accMapped;
    logic wrStrobe;
    logic rdStrobe;
    logic apbBusy_reg;
    atrb_load_t load_reg;
    logic [2:0] fuseAddr_reg;
    logic [2:0] fuseAddrLd_reg;
    logic [OFFSET_REG_W-1:0] fuseData;
    logic fuseWrite;
    logic [1:0] sel2Sync_reg;
    logic [1:0] sel3Sync_reg;

    assign accIdx = decodeIdx(paddr);
    assign accMapped = (accIdx != 4'hF);
    // Access accepted only once loading is over; registered pready gives every answer one wait state
    assign wrStrobe = psel && penable && pwrite && (load_reg == LD_DONE) && !apbBusy_reg;
    assign rdStrobe = psel && penable && !pwrite && (load_reg == LD_DONE) && !apbBusy_reg;
    assign fuseWrite = (load_reg == LD_WAIT);

    // Elaboration checks on the package layout
    generate
        if (FUSE_WORDS != NUM_GAIN + 1)
        begin : gFuseWordsCheck
            $error("fuse store needs one word for each trim register");
        end
        if (int'(FUSE_LAST) != FUSE_WORDS - 1)
        begin : gFuseLastCheck
            $error("last fuse word index does not match the store depth");
        end
        if (GAIN_W > GAIN_REG_W || OFFSET_W > OFFSET_REG_W)
        begin : gFieldCheck
            $error("trim field wider than its register");
        end
        if (OFFSET_REG_W != 16 || GAIN_REG_W > 8)
        begin : gLaneCheck
            $error("trim registers must fit the byte lanes in use");
        end
        if (ADDR_W != 14)
        begin : gAddrCheck
            $error("address width must cover the twelve-bit register index");
        end
    endgenerate

    // Fuse store
    atrb_fuse_rom #(
        .WORDS(FUSE_WORDS),
        .WIDTH(OFFSET_REG_W)
    ) uFuse (
        .clk(clk),
        .clkEn(clkEn),
        .fuseBits(fuseBits),
        .rdAddr(fuseAddr_reg),
        .rdData(fuseData)
    );

    // Fuse load sequencer after reset
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            load_reg <= LD_IDLE;
            fuseAddr_reg <= 3'h0;
            fuseAddrLd_reg <= 3'h0;
        end
        else if (clkEn)
        begin
            case (load_reg)
                LD_IDLE: load_reg <= LD_ADDR;
                LD_ADDR:
                begin
                    fuseAddrLd_reg <= fuseAddr_reg;
                    load_reg <= LD_WAIT;
                end
                LD_WAIT:
                begin
                    if (fuseAddr_reg == FUSE_LAST)
                    begin
                        load_reg <= LD_DONE;
                    end
                    else
                    begin
                        fuseAddr_reg <= fuseAddr_reg + 3'h1;
                        load_reg <= LD_ADDR;
                    end
                end
                LD_DONE: load_reg <= LD_DONE;
                default: load_reg <= LD_IDLE;
            endcase
        end
    end

    // Load finished flag, set with the last fuse word
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            fuseLoadDone <= 1'b0;
        end
        else if (clkEn && fuseWrite && fuseAddr_reg == FUSE_LAST)
        begin
            fuseLoadDone <= 1'b1;
        end
    end

    // Gain trim storage, fuse default then software writes
    genvar g;
    generate
        for (g = 0; g < NUM_GAIN; g++)
        begin : gGain
            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    gain_reg[g] <= GAIN_RESET;
                end
                else if (clkEn)
                begin
                    if (fuseWrite && fuseAddrLd_reg == 3'(g))
                    begin
                        gain_reg[g] <= fuseData[GAIN_REG_W-1:0];
                    end
                    else if (wrStrobe && accIdx == 4'(g) && pstrb[0])
                    begin
                        gain_reg[g] <= pwdata[GAIN_REG_W-1:0];
                    end
                end
            end
        end
    endgenerate

    // Core 5 offset trim storage
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            offset_reg <= OFFSET_RESET;
        end
        else if (clkEn)
        begin
            if (fuseWrite && fuseAddrLd_reg == 3'(FUSE_IDX_OFFSET))
            begin
                offset_reg <= fuseData;
            end
            else if (wrStrobe && accIdx == 4'(NUM_GAIN))
            begin
                if (pstrb[0])
                begin
                    offset_reg[7:0] <= pwdata[7:0];
                end
                if (pstrb[1])
                begin
                    offset_reg[15:8] <= pwdata[15:8];
                end
            end
        end
    end

    // Busy for one edge after an accepted access
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            apbBusy_reg <= 1'b0;
        end
        else if (clkEn)
        begin
            apbBusy_reg <= wrStrobe || rdStrobe;
        end
    end

    // Ready and error pulse for one cycle
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (clkEn)
        begin
            pready <= wrStrobe || rdStrobe;
            pslverr <= (wrStrobe || rdStrobe) && !accMapped;
        end
    end

    // Read data, held until the next answer; writes and unmapped give zero
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (clkEn && (wrStrobe || rdStrobe))
        begin
            if (rdStrobe && accIdx < 4'(NUM_GAIN))
            begin
                prdata <= {24'h00_0000, gain_reg[accIdx[2:0]]};
            end
            else if (rdStrobe && accIdx == 4'(NUM_GAIN))
            begin
                prdata <= {16'h0000, offset_reg};
            end
            else
            begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Input pair selects pass two flip-flops
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sel2Sync_reg <= 2'b00;
            sel3Sync_reg <= 2'b00;
        end
        else if (clkEn)
        begin
            sel2Sync_reg <= {sel2Sync_reg[0], core2SecondPairSel};
            sel3Sync_reg <= {sel3Sync_reg[0], core3FourthPairSel};
        end
    end

    // Gains of the single-pair cores
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            core0Gain <= 5'h00;
            core1Gain <= 5'h00;
            core4Gain <= 5'h00;
        end
        else if (clkEn)
        begin
            core0Gain <= gain_reg[0][GAIN_W-1:0];
            core1Gain <= gain_reg[1][GAIN_W-1:0];
            core4Gain <= gain_reg[6][GAIN_W-1:0];
        end
    end

    // Gains of the cores that switch input pairs
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            core2Gain <= 5'h00;
            core3Gain <= 5'h00;
        end
        else if (clkEn)
        begin
            core2Gain <= pickTrim(sel2Sync_reg[1], gain_reg[2], gain_reg[3]);
            core3Gain <= pickTrim(sel3Sync_reg[1], gain_reg[4], gain_reg[5]);
        end
    end

    // Core 5 offset trim
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            core5Offset <= 12'h000;
        end
        else if (clkEn)
        begin
            core5Offset <= offset_reg[OFFSET_W-1:0];
        end
    end
endmodule : atrb_trim_bank
`default_nettype wire

// ---- atrb_trim_bank_assertions.sv ----
// Checker for the trim bank: bus answer timing, fuse load and applied trims.
// Assumes it is bound to the bank and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module atrb_trim_bank_checker
    import atrb_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Trims
    input wire logic [GAIN_W-1:0] core0Gain,
    input wire logic [GAIN_W-1:0] core4Gain,
    input wire logic [OFFSET_W-1:0] core5Offset,
    input wire logic fuseLoadDone
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Write answered without error
    sequence s_wr(logic [13:0] a);
        pready && pwrite && !pslverr && paddr == a;
    endsequence
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready high over one cycle");
    a_ready_cause: assert property (pready |-> psel && penable && $past(penable))
        else $error("pready without two access cycles");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_load_time: assert property ($fell(rst) |-> ##[16:18] fuseLoadDone)
        else $error("fuse load not done in time");
    a_no_early: assert property (!fuseLoadDone |-> !pready)
        else $error("answer before fuse load");
    a_done_holds: assert property (fuseLoadDone |=> fuseLoadDone)
        else $error("load done dropped");
    a_core0_write: assert property (s_wr(14'h0D80) ##0 pstrb[0] |=> core0Gain == $past(pwdata[4:0]))
        else $error("core 0 trim not applied");
    a_core5_write: assert property (s_wr(14'h0CF8) ##0 pstrb[1:0] == 2'b11
        |=> core5Offset == $past(pwdata[11:0]))
        else $error("core 5 offset not applied");
    a_core4_quiet: assert property (fuseLoadDone && $past(fuseLoadDone, 2) && !pready
        |=> $stable(core4Gain))
        else $error("core 4 trim changed without write");
endmodule : atrb_trim_bank_checker
bind atrb_trim_bank atrb_trim_bank_checker u_chk (.clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .core0Gain, .core4Gain, .core5Offset,
    .fuseLoadDone);
`default_nettype wire

// ---- testbench.sv ----
// Testbench for the trim bank: fuse defaults, register rows, applied trims.
// Allows up to 40 cycles for the fuse load; bus answers are awaited, not counted.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import atrb_pkg::*;
    logic clk = 0, rst = 1, clkEn = 1, psel = 0, penable = 0, pwrite = 0, sel2 = 0, sel3 = 0;
    logic [13:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0] pstrb = 4'h0;
    logic pready, pslverr, err, done;
    logic [127:0] fuseBits;
    logic [4:0] g0, g1, g2, g3, g4;
    logic [11:0] ofs;
    int mismatches = 0, num_checks = 0;
    // Rows: byte address and value written, read back unchanged
    logic [13:0] addrs [8] = '{14'h0D80, 14'h0D84, 14'h0D88, 14'h0D8C, 14'h0D90, 14'h0D94,
        14'h0D98, 14'h0CF8};
    logic [31:0] vals [8] = '{32'h0000_0015, 32'h0000_000A, 32'h0000_001F, 32'h0000_0001,
        32'h0000_0013, 32'h0000_000C, 32'h0000_001E, 32'h0000_0A5C};
    atrb_trim_bank dut (.clk(clk), .rst(rst), .clkEn(clkEn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fuseBits(fuseBits), .core2SecondPairSel(sel2),
        .core3FourthPairSel(sel3), .core0Gain(g0), .core1Gain(g1), .core2Gain(g2),
        .core3Gain(g3), .core4Gain(g4), .core5Offset(ofs), .fuseLoadDone(done));
    initial
    begin
        forever #25 clk = ~clk;
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic rdc(input logic [13:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, 4'h0, rd, err);
        chk("read data", exp, rd);
        chk("read error", 32'h0000_0000, {31'h0, err});
    endtask : rdc
    task automatic do_reset();
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("reset outs", 32'h0000_0000, {pready, done, g0, g4, ofs, 8'h00});
        @(posedge clk);
        rst <= 1'b0;
        for (int n = 0; n < 40 && done !== 1'b1; n++)
            @(posedge clk);
        chk("load done", 32'h0000_0001, {31'h0, done});
        for (int k = 0; k < 8; k++)
            rdc(addrs[k], (k < 7) ? 32'h0000_0010 + k : 32'h0000_0ABC);
        chk("fuse trim", 32'h0000_0010, {27'h0, g0});
        chk("fuse offset", 32'h0000_0ABC, {20'h0, ofs});
    endtask : do_reset
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    initial
    begin
        repeat (3000) @(posedge clk);
        mismatches++;
        end_sim();
    end
    initial
    begin
        for (int k = 0; k < 8; k++)
            fuseBits[k*16+:16] = (k < 7) ? 16'h5A10 + 16'(k) : 16'h0ABC;
        do_reset();
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b1, addrs[i], vals[i], 4'hF, rd, err);
            chk("write error", 32'h0000_0000, {31'h0, err});
            rdc(addrs[i], vals[i]);
        end
        chk("first pairs", {vals[0][4:0], vals[1][4:0], vals[2][4:0], vals[4][4:0],
            vals[6][4:0], 7'h0}, {g0, g1, g2, g3, g4, 7'h0});
        sel2 <= 1'b1;
        sel3 <= 1'b1;
        repeat (5) @(posedge clk);
        chk("second pairs", {vals[3][4:0], vals[5][4:0], 10'h0, vals[7][11:0]},
            {g2, g3, 10'h0, ofs});
        clkEn <= 1'b0;
        sel2 <= 1'b0;
        repeat (5) @(posedge clk);
        chk("frozen trim", {27'h0, vals[3][4:0]}, {27'h0, g2});
        clkEn <= 1'b1;
        repeat (5) @(posedge clk);
        chk("first pair again", {27'h0, vals[2][4:0]}, {27'h0, g2});
        apb(1'b1, 14'h0D9C, 32'h0000_001F, 4'hF, rd, err);
        chk("unmapped write error", 32'h0000_0001, {31'h0, err});
        apb(1'b0, 14'h0D9C, 32'h0000_0000, 4'h0, rd, err);
        chk("unmapped data", 32'h0000_0000, rd);
        chk("unmapped error", 32'h0000_0001, {31'h0, err});
        rdc(addrs[6], vals[6]);
        apb(1'b1, addrs[7], 32'h0000_0F00, 4'h2, rd, err);
        rdc(addrs[7], {vals[7][31:16], 8'h0F, vals[7][7:0]});
        do_reset();
        end_sim();
    end
endmodule : testbench
`default_nettype wire
